// [eiobp_pkg.sv]
// shared constants and types for the extended i/o block port
package eiobp_pkg;

    // point and group geometry
    localparam int GROUP_BITS = 8;
    localparam int NUM_EXT_BLOCKS = 8;
    localparam int NUM_GROUPS = 9;
    localparam int EXT_POINTS = 64;
    localparam int BW_EXT_ARGS = 4;
    localparam int BW_ARGS = 5;

    // point index ranges
    localparam logic [6:0] POINT_GEN_FIRST = 7'h01;
    localparam logic [6:0] POINT_GEN_LAST = 7'h08;
    localparam logic [6:0] POINT_EXT_FIRST = 7'h11;
    localparam logic [6:0] POINT_EXT_LAST = 7'h50;

    // block numbers seen by software
    localparam logic [3:0] BLOCK_GENERAL = 4'h0;
    localparam logic [3:0] BLOCK_EXT_FIRST = 4'h2;
    localparam logic [3:0] BLOCK_EXT_LAST = 4'h9;

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_DIR_CFG = 8'h00;
    localparam logic [7:0] OFF_POINT_CMD = 8'h04;
    localparam logic [7:0] OFF_POINT_SEL = 8'h08;
    localparam logic [7:0] OFF_POINT_LEVEL = 8'h0C;
    localparam logic [7:0] OFF_BW_ARG0 = 8'h10;
    localparam logic [7:0] OFF_BW_ARG1 = 8'h14;
    localparam logic [7:0] OFF_BW_ARG2 = 8'h18;
    localparam logic [7:0] OFF_BW_ARG3 = 8'h1C;
    localparam logic [7:0] OFF_BW_ARG4 = 8'h20;
    localparam logic [7:0] OFF_BW_GO = 8'h24;
    localparam logic [7:0] OFF_SAVE = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2C;
    localparam logic [7:0] OFF_BLOCK_BASE = 8'h40;
    localparam logic [7:0] OFF_BLOCK_LAST = 8'h64;

    // point command field layout
    localparam int PC_INDEX_LSB = 0;
    localparam int PC_OP_LSB = 8;
    localparam int PC_COND_BIT = 12;
    localparam logic [1:0] PC_OP_SET = 2'h0;
    localparam logic [1:0] PC_OP_CLEAR = 2'h1;
    localparam logic [1:0] PC_OP_COND = 2'h2;

    // status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SAVED_BIT = 1;

    // reset values
    localparam logic [7:0] DIR_CFG_RESET = 8'h00;
    localparam logic [7:0] OUT_RESET = 8'h00;

    // nonvolatile image: word 0 direction, words 1..9 groups 0..8
    localparam logic [3:0] NV_WORD_DIR = 4'h0;
    localparam logic [3:0] NV_WORD_LAST = 4'h9;
    localparam logic [3:0] LOAD_STEP_LAST = 4'hA;

    typedef enum logic [1:0] {ST_BOOT, ST_LOAD, ST_IDLE, ST_SAVE} eiobp_state_t;

endpackage

// [eiobp_core_if.sv]
// carrier between the control core, the pin bank and the image memory
`timescale 1ns/1ps
interface eiobp_core_if;
    logic [7:0] dir;
    logic [8:0][7:0] outs;
    logic [8:0][7:0] level;
    logic mem_we;
    logic [3:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic mem_valid;

    modport core (output dir, outs, mem_we, mem_addr, mem_wdata,
                  input level, mem_rdata, mem_valid);
    modport bank (input dir, outs, output level);
    modport mem (input mem_we, mem_addr, mem_wdata, output mem_rdata, mem_valid);
endinterface

// [eiobp_nv_mem.sv]
// image memory holding saved direction and output states
`timescale 1ns/1ps
module eiobp_nv_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic nv_erase_i,
    eiobp_core_if.mem mem
);
    logic [WIDTH-1:0] cells [DEPTH];
    logic [WIDTH-1:0] rd_word;
    logic saved;

    // cells keep their content across system reset
    always_ff @(posedge clock_i)
    begin
        if (mem.mem_we)
        begin
            cells[mem.mem_addr] <= mem.mem_wdata;
        end
        rd_word <= cells[mem.mem_addr];
    end

    // valid only once the last word landed, so a torn save is never restored unless an earlier save already set it
    always_ff @(posedge clock_i)
    begin
        if (mem.mem_we && mem.mem_addr == eiobp_pkg::NV_WORD_LAST)
        begin
            saved <= 1'b1;
        end
        else if (nv_erase_i)
        begin
            saved <= 1'b0;
        end
    end

    assign mem.mem_rdata = rd_word;
    assign mem.mem_valid = saved;
endmodule

// [eiobp_pin_bank.sv]
// pin drivers, input sampling and per-point level view
`timescale 1ns/1ps
module eiobp_pin_bank (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [63:0] ext_in_i,
    output logic [7:0] gen_out_o,
    output logic [63:0] ext_out_o,
    output logic [63:0] ext_oe_n_o,
    eiobp_core_if.bank bank
);
    logic [63:0] pin_sample;
    logic [8:0][7:0] level;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            gen_out_o <= eiobp_pkg::OUT_RESET;
            pin_sample <= '0;
            level[0] <= eiobp_pkg::OUT_RESET;
        end
        else
        begin
            gen_out_o <= bank.outs[0];
            pin_sample <= ext_in_i;
            level[0] <= bank.outs[0];
        end
    end

    for (genvar b = 0; b < eiobp_pkg::NUM_EXT_BLOCKS; b++)
    begin : g_block
        always_ff @(posedge clock_i)
        begin
            if (sys_rst_i)
            begin
                ext_out_o[b*8 +: 8] <= eiobp_pkg::OUT_RESET;
                ext_oe_n_o[b*8 +: 8] <= 8'hFF;
                level[b+1] <= eiobp_pkg::OUT_RESET;
            end
            else
            begin
                ext_out_o[b*8 +: 8] <= bank.outs[b+1];
                ext_oe_n_o[b*8 +: 8] <= {8{~bank.dir[b]}};
                // outputs read back their own state, inputs the pin
                level[b+1] <= bank.dir[b] ? bank.outs[b+1] : pin_sample[b*8 +: 8];
            end
        end
    end

    assign bank.level = level;
endmodule

// [eiobp_top.sv]
// extended i/o block port: register port, point and block commands, save and restore
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - there are 64 extended points in eight blocks of eight, blocks 2 to 9, points 17 to 80.
// - the direction word has one bit per block, bit 0 for block 2 up to bit 7 for block 9.
// - a direction bit of one makes its whole block an output, zero makes it an input.
// - with nothing saved, startup uses a direction word of zero so all blocks are inputs.
// - a save command stores the direction word and all output states for later restore.
// - set and clear act on one point 1 to 8 or 17 to 80, only where its block is an output.
// - the conditional command drives the point high when the condition is true, else low.
// - block write takes an 8-bit general argument and four 16-bit pair arguments, low block low.
// - block write drops argument bits that land on input blocks, leaving them unchanged.
// - each supplied argument overwrites its whole group, omitted ones keep their values.
// - block read takes block 0 or 2 to 9 and returns its eight levels, lowest point at bit 0.
// - point read takes 1 to 8 or 17 to 80 and returns its level, 17 being block 2 bit 0.
// - general outputs 1 to 8 are block 0, always outputs, untouched by the direction word.
module eiobp_top (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic nv_erase_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [31:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [31:0] bus_rdata_o,
    input wire logic [63:0] ext_in_i,
    output logic [7:0] gen_out_o,
    output logic [63:0] ext_out_o,
    output logic [63:0] ext_oe_n_o
);
    eiobp_core_if core_if();

    eiobp_pkg::eiobp_state_t state;
    logic [3:0] step;
    logic [7:0] dir;
    logic [8:0][7:0] outs;
    logic [7:0] bw_gen;
    logic [3:0][15:0] bw_ext;
    logic [6:0] point_sel;
    logic idle;
    logic wr_dir;
    logic wr_point;
    logic wr_bw_go;
    logic wr_save;
    logic [7:0] cmd_map;
    logic [7:0] sel_map;
    logic cmd_target_out;
    logic next_bit;
    logic [1:0] cmd_op;
    logic [31:0] rd_value;
    logic [3:0] blk_num;
    logic cmd_op_ok;
    logic point_go;
    logic bw_go;
    logic [eiobp_pkg::BW_ARGS-1:0] bw_mask;
    logic blk_hit;
    logic sel_level;

    // maps a point index to {valid, group, bit}; group 0 is the general port
    function automatic logic [7:0] point_map(input logic [6:0] idx);
        logic [6:0] rel;
        logic [3:0] grp;
        rel = idx - eiobp_pkg::POINT_EXT_FIRST;
        grp = {1'b0, rel[5:3]} + 4'h1;
        // indices outside both ranges stay invalid
        point_map = 8'h00;
        if (idx >= eiobp_pkg::POINT_GEN_FIRST && idx <= eiobp_pkg::POINT_GEN_LAST)
        begin
            point_map = {1'b1, 4'h0, rel[2:0]};
        end
        else if (idx >= eiobp_pkg::POINT_EXT_FIRST && idx <= eiobp_pkg::POINT_EXT_LAST)
        begin
            point_map = {1'b1, grp, rel[2:0]};
        end
        // general index bit is idx-1, equal to rel low bits since 17 and 1 differ by 16
    endfunction

    // group 0 is always writable, extended groups follow their direction bit
    function automatic logic group_is_out(input logic [3:0] grp, input logic [7:0] cfg);
        logic [3:0] blk;
        blk = grp - 4'h1;
        if (grp == 4'h0)
        begin
            group_is_out = 1'b1;
        end
        else
        begin
            group_is_out = cfg[blk[2:0]];
        end
    endfunction

    assign idle = (state == eiobp_pkg::ST_IDLE);
    assign wr_dir = bus_wr_i && bus_addr_i == eiobp_pkg::OFF_DIR_CFG;
    assign wr_point = bus_wr_i && bus_addr_i == eiobp_pkg::OFF_POINT_CMD;
    assign wr_bw_go = bus_wr_i && bus_addr_i == eiobp_pkg::OFF_BW_GO;
    assign wr_save = bus_wr_i && bus_addr_i == eiobp_pkg::OFF_SAVE;

    assign cmd_map = point_map(bus_wdata_i[eiobp_pkg::PC_INDEX_LSB +: 7]);
    assign sel_map = point_map(point_sel);
    assign cmd_op = bus_wdata_i[eiobp_pkg::PC_OP_LSB +: 2];
    assign cmd_target_out = cmd_map[7] && group_is_out(cmd_map[6:3], dir);

    // reserved op codes are dropped, not taken as a clear
    assign point_go = idle && wr_point && cmd_target_out && cmd_op_ok;
    // dropped while busy: a queued command would act on a torn image
    assign bw_go = idle && wr_bw_go;
    assign bw_mask = bus_wdata_i[eiobp_pkg::BW_ARGS-1:0];

    always_comb
    begin
        next_bit = 1'b0;
        cmd_op_ok = 1'b1;
        case (cmd_op)
            eiobp_pkg::PC_OP_SET: next_bit = 1'b1;
            eiobp_pkg::PC_OP_CLEAR: next_bit = 1'b0;
            eiobp_pkg::PC_OP_COND: next_bit = bus_wdata_i[eiobp_pkg::PC_COND_BIT];
            default: cmd_op_ok = 1'b0;
        endcase
    end

    // sequencer: boot check, restore from image, idle, save to image
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            state <= eiobp_pkg::ST_BOOT;
            step <= 4'h0;
        end
        else
        begin
            case (state)
                eiobp_pkg::ST_BOOT:
                begin
                    step <= 4'h0;
                    // nothing saved means the reset defaults stay in force
                    state <= core_if.mem_valid ? eiobp_pkg::ST_LOAD : eiobp_pkg::ST_IDLE;
                end
                eiobp_pkg::ST_LOAD:
                begin
                    // step 1 takes the direction word, steps 2 to 10 the groups
                    step <= step + 4'h1;
                    if (step == eiobp_pkg::LOAD_STEP_LAST)
                    begin
                        state <= eiobp_pkg::ST_IDLE;
                    end
                end
                eiobp_pkg::ST_IDLE:
                begin
                    step <= 4'h0;
                    if (wr_save)
                    begin
                        state <= eiobp_pkg::ST_SAVE;
                    end
                end
                eiobp_pkg::ST_SAVE:
                begin
                    // pins keep driving while the image is written
                    step <= step + 4'h1;
                    if (step == eiobp_pkg::NV_WORD_LAST)
                    begin
                        state <= eiobp_pkg::ST_IDLE;
                    end
                end
                // a stray state restarts at the boot check, restoring only if an image is saved
                default:
                begin
                    state <= eiobp_pkg::ST_BOOT;
                    step <= 4'h0;
                end
            endcase
        end
    end

    // image port: read address leads the data by one cycle
    assign core_if.mem_we = (state == eiobp_pkg::ST_SAVE);
    assign core_if.mem_addr = step;
    assign core_if.mem_wdata = (step == eiobp_pkg::NV_WORD_DIR) ? dir : outs[step[3:0] - 4'h1];

    // direction word
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            dir <= eiobp_pkg::DIR_CFG_RESET;
        end
        else if (state == eiobp_pkg::ST_LOAD && step == 4'h1)
        begin
            dir <= core_if.mem_rdata;
        end
        // a write during save or restore would tear the image
        else if (idle && wr_dir)
        begin
            dir <= bus_wdata_i[7:0];
        end
    end

    // output states; commands are dropped while saving or restoring
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            outs <= '0;
        end
        else if (state == eiobp_pkg::ST_LOAD)
        begin
            if (step >= 4'h2)
            begin
                outs[step - 4'h2] <= core_if.mem_rdata;
            end
        end
        else if (point_go)
        begin
            outs[cmd_map[6:3]][cmd_map[2:0]] <= next_bit;
        end
        else if (bw_go)
        begin
            if (bw_mask[0])
            begin
                outs[0] <= bw_gen;
            end
            for (int g = 1; g < eiobp_pkg::NUM_GROUPS; g++)
            begin
                // odd groups take the low byte of their pair argument
                // an input block drops its byte even if its pair partner takes one
                if (bw_mask[(g + 1) / 2] && group_is_out(4'(g), dir))
                begin
                    outs[g] <= (g % 2 == 1) ? bw_ext[(g - 1) / 2][7:0]
                                            : bw_ext[(g - 1) / 2][15:8];
                end
            end
        end
    end

    // block write argument staging and point read selector
    // staged arguments outlive a block write and may be reused
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            bw_gen <= 8'h00;
            bw_ext <= '0;
            point_sel <= 7'h00;
        end
        else if (bus_wr_i)
        begin
            case (bus_addr_i)
                eiobp_pkg::OFF_BW_ARG0: bw_gen <= bus_wdata_i[7:0];
                eiobp_pkg::OFF_BW_ARG1: bw_ext[0] <= bus_wdata_i[15:0];
                eiobp_pkg::OFF_BW_ARG2: bw_ext[1] <= bus_wdata_i[15:0];
                eiobp_pkg::OFF_BW_ARG3: bw_ext[2] <= bus_wdata_i[15:0];
                eiobp_pkg::OFF_BW_ARG4: bw_ext[3] <= bus_wdata_i[15:0];
                eiobp_pkg::OFF_POINT_SEL: point_sel <= bus_wdata_i[6:0];
                default: point_sel <= point_sel;
            endcase
        end
    end

    // read decode; block 1 and unmapped addresses read zero
    assign blk_num = bus_addr_i[5:2];
    // only aligned words inside the block window decode
    assign blk_hit = bus_addr_i >= eiobp_pkg::OFF_BLOCK_BASE
        && bus_addr_i <= eiobp_pkg::OFF_BLOCK_LAST && bus_addr_i[1:0] == 2'h0;
    // an invalid index reads level zero beside valid zero
    assign sel_level = sel_map[7] && core_if.level[sel_map[6:3]][sel_map[2:0]];

    always_comb
    begin
        rd_value = 32'h0000_0000;
        case (bus_addr_i)
            eiobp_pkg::OFF_DIR_CFG: rd_value = {24'h00_0000, dir};
            eiobp_pkg::OFF_POINT_SEL: rd_value = {25'h000_0000, point_sel};
            eiobp_pkg::OFF_POINT_LEVEL:
            begin
                rd_value[1] = sel_map[7];
                rd_value[0] = sel_level;
            end
            eiobp_pkg::OFF_BW_ARG0: rd_value = {24'h00_0000, bw_gen};
            eiobp_pkg::OFF_BW_ARG1: rd_value = {16'h0000, bw_ext[0]};
            eiobp_pkg::OFF_BW_ARG2: rd_value = {16'h0000, bw_ext[1]};
            eiobp_pkg::OFF_BW_ARG3: rd_value = {16'h0000, bw_ext[2]};
            eiobp_pkg::OFF_BW_ARG4: rd_value = {16'h0000, bw_ext[3]};
            eiobp_pkg::OFF_STATUS:
            begin
                rd_value[eiobp_pkg::ST_BUSY_BIT] = !idle;
                rd_value[eiobp_pkg::ST_SAVED_BIT] = core_if.mem_valid;
            end
            default:
            begin
                if (blk_hit)
                begin
                    if (blk_num == eiobp_pkg::BLOCK_GENERAL)
                    begin
                        rd_value = {24'h00_0000, core_if.level[0]};
                    end
                    else if (blk_num >= eiobp_pkg::BLOCK_EXT_FIRST)
                    begin
                        rd_value = {24'h00_0000, core_if.level[blk_num - 4'h1]};
                    end
                end
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            bus_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            bus_rdata_o <= bus_rd_i ? rd_value : 32'h0000_0000;
        end
    end

    // bank and image see the same registered state
    assign core_if.dir = dir;
    assign core_if.outs = outs;

    // pins lag the internal state by one edge
    eiobp_pin_bank u_bank (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .ext_in_i(ext_in_i),
        .gen_out_o(gen_out_o),
        .ext_out_o(ext_out_o),
        .ext_oe_n_o(ext_oe_n_o),
        .bank(core_if.bank)
    );

    // image survives sys_rst_i, only nv_erase_i blanks it
    eiobp_nv_mem #(
        .DEPTH(16),
        .WIDTH(8)
    ) u_mem (
        .clock_i(clock_i),
        .nv_erase_i(nv_erase_i),
        .mem(core_if.mem)
    );
endmodule

// [eiobp_top_properties.sv]
// concurrent checks on the pins and register port of the extended i/o block port
`timescale 1ns/1ps
module eiobp_top_properties (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [31:0] bus_rdata_o,
    input wire logic [7:0] gen_out_o,
    input wire logic [63:0] ext_out_o,
    input wire logic [63:0] ext_oe_n_o
);
    logic [4:0] since_rst;
    logic oe_uniform;
    logic [7:0] dir_seen;
    logic cmd_wr;
    logic dir_wr;
    // restore after a reset may move the pins, so changes are free until the count saturates
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            since_rst <= 5'h00;
        else if (since_rst != 5'h1F)
            since_rst <= since_rst + 5'h01;
    end
    always_comb
    begin
        oe_uniform = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            dir_seen[k] = ~ext_oe_n_o[k*8];
            if (ext_oe_n_o[k*8 +: 8] != {8{ext_oe_n_o[k*8]}})
                oe_uniform = 1'b0;
        end
    end
    assign cmd_wr = bus_wr_i && (bus_addr_i == eiobp_pkg::OFF_POINT_CMD
                    || bus_addr_i == eiobp_pkg::OFF_BW_GO);
    assign dir_wr = bus_wr_i && bus_addr_i == eiobp_pkg::OFF_DIR_CFG;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    a_oe_whole_block: assert property (oe_uniform)
        else $error("output enable differs inside one block");
    a_rst_quiet: assert property ($fell(sys_rst_i) |-> ext_oe_n_o == '1
        && gen_out_o == 8'h00 && ext_out_o == 64'h0)
        else $error("pins not quiet after reset");
    a_rdata_idle: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 32'h0)
        else $error("read data not zero outside read slot");
    a_dead_block: assert property ($past(bus_rd_i) && ($past(bus_addr_i) == 8'h44
        || $past(bus_addr_i) == 8'h30) |-> bus_rdata_o == 32'h0)
        else $error("block 1 or unmapped read not zero");
    a_gen_readback: assert property ($past(bus_rd_i)
        && $past(bus_addr_i) == eiobp_pkg::OFF_BLOCK_BASE
        |-> bus_rdata_o == {24'h00_0000, gen_out_o})
        else $error("block 0 read differs from general outputs");
    a_dir_readback: assert property ($past(bus_rd_i)
        && $past(bus_addr_i) == eiobp_pkg::OFF_DIR_CFG
        |-> bus_rdata_o == {24'h00_0000, dir_seen})
        else $error("direction read differs from enables");
    a_oe_cause: assert property ($changed(ext_oe_n_o) |-> since_rst != 5'h1F
        || $past(dir_wr, 2))
        else $error("enables moved without direction write");
    a_gen_cause: assert property ($changed(gen_out_o) |-> since_rst != 5'h1F
        || $past(cmd_wr, 2) || $past(cmd_wr, 3))
        else $error("general outputs moved without command");
    a_ext_cause: assert property ($changed(ext_out_o & ~ext_oe_n_o)
        |-> since_rst != 5'h1F || $past(cmd_wr, 2) || $past(cmd_wr, 3) || $past(dir_wr, 2))
        else $error("driven extended outputs moved without command");
endmodule
bind eiobp_top eiobp_top_properties eiobp_top_properties_i (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o),
    .gen_out_o(gen_out_o),
    .ext_out_o(ext_out_o),
    .ext_oe_n_o(ext_oe_n_o)
);

// [eiobp_rack_model.sv]
// mounting rack and field wiring seen by the extended pins
`timescale 1ns/1ps
module eiobp_rack_model (
    input wire logic [63:0] ext_out_i,
    input wire logic [63:0] ext_oe_n_i,
    input wire logic [63:0] field_i,
    output logic [63:0] pins_o
);
    always_comb
    begin
        for (int k = 0; k < 64; k++)
        begin
            if (!ext_oe_n_i[k])
                pins_o[k] = ext_out_i[k];
            else if (k / 8 == 3 || k / 8 == 7)
                pins_o[k] = 1'b0;
            else
                pins_o[k] = field_i[k];
        end
    end
endmodule

// [eiobp_tb.sv]
// self-checking bench for the extended i/o block port
`timescale 1ns/1ps
module eiobp_tb;
    typedef struct packed
    {
        logic [31:0] cmd;
        logic [7:0] gen;
        logic [63:0] ext;
    } eiobp_row_t;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic nv_erase_i = 1'b1;
    logic [7:0] bus_addr_i = 8'h00;
    logic [31:0] bus_wdata_i = 32'h0000_0000;
    logic bus_wr_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic [31:0] bus_rdata_o;
    logic [63:0] ext_in_i;
    logic [7:0] gen_out_o;
    logic [63:0] ext_out_o;
    logic [63:0] ext_oe_n_o;
    logic [63:0] field = 64'h1357_9BDF_2468_ACE0;
    logic [7:0] dir = 8'h00;
    logic [7:0] eg = 8'h00;
    logic [63:0] ee = 64'h0;
    logic [31:0] d;
    int mismatches = 0;
    int n_compared = 0;
    eiobp_row_t rows [13] = '{
        '{32'h0000_0001, 8'h01, 64'h0}, '{32'h0000_0008, 8'h81, 64'h0},
        '{32'h0000_0101, 8'h80, 64'h0}, '{32'h0000_0011, 8'h80, 64'h1},
        '{32'h0000_0311, 8'h80, 64'h1},
        '{32'h0000_0048, 8'h80, 64'h0080_0000_0000_0001},
        '{32'h0000_0019, 8'h80, 64'h0080_0000_0000_0001},
        '{32'h0000_1212, 8'h80, 64'h0080_0000_0000_0003},
        '{32'h0000_0248, 8'h80, 64'h3}, '{32'h0000_0208, 8'h00, 64'h3},
        '{32'h0000_0009, 8'h00, 64'h3}, '{32'h0000_0050, 8'h00, 64'h3},
        '{32'h0000_0051, 8'h00, 64'h3}};
    always #2.5 clock_i = ~clock_i;
    eiobp_top eiobp_top_i (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .nv_erase_i(nv_erase_i),
        .bus_addr_i(bus_addr_i),
        .bus_wdata_i(bus_wdata_i),
        .bus_wr_i(bus_wr_i),
        .bus_rd_i(bus_rd_i),
        .bus_rdata_o(bus_rdata_o),
        .ext_in_i(ext_in_i),
        .gen_out_o(gen_out_o),
        .ext_out_o(ext_out_o),
        .ext_oe_n_o(ext_oe_n_o)
    );
    eiobp_rack_model eiobp_rack_model_i (
        .ext_out_i(ext_out_o),
        .ext_oe_n_i(ext_oe_n_o),
        .field_i(field),
        .pins_o(ext_in_i)
    );
    function automatic logic [63:0] omask(input logic [7:0] c);
        for (int k = 0; k < 8; k++)
            omask[k*8 +: 8] = {8{c[k]}};
    endfunction
    // rack grounds blocks 5 and 9, so they read zero as inputs
    function automatic logic [7:0] blk(input int n);
        if (n == 0)
            return eg;
        if (n == 1)
            return 8'h00;
        if (dir[n-2])
            return ee[(n-2)*8 +: 8];
        if (n == 5 || n == 9)
            return 8'h00;
        return field[(n-2)*8 +: 8];
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one idle edge after each strobe keeps every driver to one assignment per step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus_addr_i <= a;
        bus_wdata_i <= v;
        bus_wr_i <= 1'b1;
        @(posedge clock_i);
        bus_wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge clock_i);
        bus_rd_i <= 1'b0;
        #1;
        v = bus_rdata_o;
        @(posedge clock_i);
    endtask
    task automatic settle;
        repeat (4) @(posedge clock_i);
        #1;
    endtask
    task automatic pins_chk;
        chk("gen_out_o", {56'h0, eg}, {56'h0, gen_out_o});
        chk("ext_oe_n_o", ~omask(dir), ext_oe_n_o);
        chk("ext_out_o", ee & omask(dir), ext_out_o & omask(dir));
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        final_report();
    end
    initial
    begin
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        nv_erase_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rd(eiobp_pkg::OFF_STATUS, d);
        chk("status", 64'h0, {32'h0, d});
        rd(eiobp_pkg::OFF_DIR_CFG, d);
        chk("dir_cfg", 64'h0, {32'h0, d});
        pins_chk();
        dir = 8'h41;
        wr(eiobp_pkg::OFF_DIR_CFG, {24'h00_0000, dir});
        settle();
        pins_chk();
        rd(eiobp_pkg::OFF_DIR_CFG, d);
        chk("dir_cfg", {56'h0, dir}, {32'h0, d});
        foreach (rows[i])
        begin
            wr(eiobp_pkg::OFF_POINT_CMD, rows[i].cmd);
            settle();
            eg = rows[i].gen;
            ee = rows[i].ext;
            pins_chk();
        end
        wr(eiobp_pkg::OFF_POINT_SEL, 32'h0000_0011);
        rd(eiobp_pkg::OFF_POINT_LEVEL, d);
        chk("point_17", 64'h3, {32'h0, d});
        wr(eiobp_pkg::OFF_POINT_SEL, 32'h0000_0019);
        rd(eiobp_pkg::OFF_POINT_LEVEL, d);
        chk("point_25", {62'h0, 1'b1, field[8]}, {32'h0, d});
        wr(eiobp_pkg::OFF_BW_ARG0, 32'h0000_00F7);
        wr(eiobp_pkg::OFF_BW_ARG1, 32'h0000_FFFF);
        wr(eiobp_pkg::OFF_BW_ARG2, 32'h0000_1234);
        wr(eiobp_pkg::OFF_BW_ARG4, 32'h0000_0707);
        wr(eiobp_pkg::OFF_BW_GO, 32'h0000_0013);
        settle();
        eg = 8'hF7;
        ee = 64'h0007_0000_0000_00FF;
        pins_chk();
        wr(eiobp_pkg::OFF_BW_ARG0, 32'h0000_0055);
        wr(eiobp_pkg::OFF_BW_GO, 32'h0000_0001);
        settle();
        eg = 8'h55;
        pins_chk();
        for (int n = 0; n < 10; n++)
        begin
            rd(eiobp_pkg::OFF_BLOCK_BASE + 8'(4 * n), d);
            chk("block_read", {56'h0, blk(n)}, {32'h0, d});
        end
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, d);
        chk("unmapped", 64'h0, {32'h0, d});
        wr(eiobp_pkg::OFF_SAVE, 32'h0000_0001);
        d = 32'h0000_0001;
        for (int t = 0; t < 40 && d[0]; t++)
            rd(eiobp_pkg::OFF_STATUS, d);
        chk("status", 64'h2, {32'h0, d});
        wr(eiobp_pkg::OFF_DIR_CFG, 32'h0000_0000);
        wr(eiobp_pkg::OFF_BW_ARG0, 32'h0000_0000);
        wr(eiobp_pkg::OFF_BW_GO, 32'h0000_0001);
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (20) @(posedge clock_i);
        #1;
        pins_chk();
        rd(eiobp_pkg::OFF_DIR_CFG, d);
        chk("dir_cfg", {56'h0, dir}, {32'h0, d});
        final_report();
    end
endmodule
